//--- ppp_pkg.sv
package ppp_pkg;
    // command bytes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h80;

    // load strobe actions, {action_select_hi, action_select_lo}
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;

    // fuse byte select, {byte_select_two, byte_select_one}
    localparam logic [1:0] FSEL_LOW = 2'h0;
    localparam logic [1:0] FSEL_HIGH = 2'h1;
    localparam logic [1:0] FSEL_EXT = 2'h2;

    // memory geometry
    localparam int FLASH_AW = 14;
    localparam int PAGE_AW = 6;
    localparam int EE_AW = 10;
    localparam int EE_PAGE_AW = 2;
    localparam int FIFO_DEPTH = 32;

    // reset values of fuses and lock byte, 0 means programmed
    localparam logic [7:0] FUSE_LOW_RST = 8'h62;
    localparam logic [7:0] FUSE_HIGH_RST = 8'hff;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam int EE_KEEP_BIT = 3;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_PROG_NS = 3_700_000;
    localparam int T_ERASE_NS = 7_500_000;
    localparam int PROG_CYC = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYC = (T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DRAIN,
        ST_ERASE_FL,
        ST_ERASE_EE,
        ST_PROG_FL,
        ST_PROG_EE,
        ST_WAIT
    } ppp_state_t;
endpackage : ppp_pkg

//--- ppp_port.sv
`timescale 1ns/100ps

module ppp_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ppp_fifo_st_t;

    ppp_fifo_st_t cur;
    ppp_fifo_st_t nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = cur.cnt != (AW+1)'(DEPTH);
    assign out_valid = cur.cnt != '0;
    assign out_data = mem[cur.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointers wrap explicitly so depth need not be a power of two
    always_comb
    begin
        nxt = cur;
        if (push)
        begin
            nxt.wp = (cur.wp == AW'(DEPTH - 1)) ? '0 : cur.wp + 1'b1;
        end
        if (pop)
        begin
            nxt.rp = (cur.rp == AW'(DEPTH - 1)) ? '0 : cur.rp + 1'b1;
        end
        nxt.cnt = cur.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= nxt;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[cur.wp] <= in_data;
        end
    end
endmodule : ppp_fifo

module ppp_port
    import ppp_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC,
    parameter int FLASH_ADDR_W = FLASH_AW,
    parameter int PAGE_ADDR_W = PAGE_AW,
    parameter int EE_ADDR_W = EE_AW,
    parameter int EE_PAGE_ADDR_W = EE_PAGE_AW,
    parameter int LATCH_DEPTH = FIFO_DEPTH
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PROG_HV,
    input wire logic ACTION_SELECT_HI,
    input wire logic ACTION_SELECT_LO,
    input wire logic BYTE_SELECT_ONE,
    input wire logic BYTE_SELECT_TWO,
    input wire logic LOAD_STROBE,
    input wire logic PAGE_LATCH_STROBE,
    input wire logic WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE_N,
    output logic PROGRAM_DONE_FLAG,
    output logic PROG_MODE,
    output logic PAGE_LATCH_READY,
    output logic [7:0] FUSE_LOW,
    output logic [7:0] FUSE_HIGH,
    output logic [7:0] FUSE_EXT,
    output logic [7:0] LOCK_BITS
);
    localparam int FLASH_WORDS = 1 << FLASH_ADDR_W;
    localparam int PAGE_WORDS = 1 << PAGE_ADDR_W;
    localparam int EE_BYTES = 1 << EE_ADDR_W;
    localparam int EE_PAGE = 1 << EE_PAGE_ADDR_W;
    localparam int FW = PAGE_ADDR_W + 16;

    typedef struct packed {
        logic mode;
        logic hv_q;
        logic ld_q;
        logic pl_q;
        logic wr_q;
        logic [7:0] cmd;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] data_lo;
        logic [7:0] data_hi;
        logic [7:0] fuse_low;
        logic [7:0] fuse_high;
        logic [7:0] fuse_ext;
        logic [7:0] lock;
        ppp_state_t st;
        logic [FLASH_ADDR_W-1:0] idx;
        logic [31:0] cnt;
        logic [PAGE_WORDS-1:0] bvalid;
        logic [7:0] dout;
        logic doe_n;
        logic rdy;
        logic plr;
    } ppp_st_t;

    localparam ppp_st_t RST_ST = '{
        st: ST_IDLE,
        fuse_low: FUSE_LOW_RST,
        fuse_high: FUSE_HIGH_RST,
        fuse_ext: FUSE_EXT_RST,
        lock: LOCK_RST,
        doe_n: 1'b1,
        rdy: 1'b1,
        wr_q: 1'b1,
        default: '0
    };

    ppp_st_t cur;
    ppp_st_t nxt;

    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [15:0] page_buf [PAGE_WORDS];

    logic fl_we;
    logic [FLASH_ADDR_W-1:0] fl_wa;
    logic [15:0] fl_wd;
    logic ee_we;
    logic [EE_ADDR_W-1:0] ee_wa;
    logic bf_we;
    logic [PAGE_ADDR_W-1:0] bf_wa;
    logic [15:0] bf_wd;

    logic f_in_valid;
    logic f_in_ready;
    logic [FW-1:0] f_in_data;
    logic f_out_valid;
    logic f_out_ready;
    logic [FW-1:0] f_out_data;

    logic [15:0] addr16;
    logic [FLASH_ADDR_W-1:0] faddr;
    logic [EE_ADDR_W-1:0] eaddr;
    logic [PAGE_ADDR_W-1:0] widx;
    logic [PAGE_ADDR_W-1:0] pidx;
    logic hv_rise;
    logic ld_rise;
    logic pl_rise;
    logic wr_fall;
    logic ee_keep;

    // address byte pair forms word address for flash, byte address for eeprom
    assign addr16 = {cur.addr_hi, cur.addr_lo};
    assign faddr = addr16[FLASH_ADDR_W-1:0];
    assign eaddr = addr16[EE_ADDR_W-1:0];
    assign pidx = cur.idx[PAGE_ADDR_W-1:0];

    // strobes are synchronous inputs, one register each for edges
    assign hv_rise = PROG_HV && !cur.hv_q;
    assign ld_rise = LOAD_STROBE && !cur.ld_q;
    assign pl_rise = PAGE_LATCH_STROBE && !cur.pl_q;
    assign wr_fall = cur.wr_q && !WRITE_N;
    assign ee_keep = !cur.fuse_high[EE_KEEP_BIT];

    // eeprom pages use only the low index bits of the word position
    assign widx = (cur.cmd == CMD_WR_EEPROM) ?
        (cur.addr_lo[PAGE_ADDR_W-1:0] & PAGE_ADDR_W'(EE_PAGE - 1)) :
        cur.addr_lo[PAGE_ADDR_W-1:0];

    // page latch pushes index and data word; full fifo drops the pulse
    assign f_in_valid = cur.mode && pl_rise;
    assign f_in_data = {widx, cur.data_hi, cur.data_lo};
    // buffer is frozen while a page is being programmed
    assign f_out_ready = (cur.st == ST_IDLE) || (cur.st == ST_DRAIN);

    ppp_fifo #(
        .WIDTH(FW),
        .DEPTH(LATCH_DEPTH)
    ) u_latch_fifo (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    always_comb
    begin
        nxt = cur;
        fl_we = 1'b0;
        fl_wa = '0;
        fl_wd = '0;
        ee_we = 1'b0;
        ee_wa = '0;
        bf_we = 1'b0;
        bf_wa = '0;
        bf_wd = '0;
        nxt.hv_q = PROG_HV;
        nxt.ld_q = LOAD_STROBE;
        nxt.pl_q = PAGE_LATCH_STROBE;
        nxt.wr_q = WRITE_N;

        // entry pattern is checked on the high-voltage edge only
        if (!PROG_HV)
        begin
            nxt.mode = 1'b0;
        end
        else if (hv_rise && !PAGE_LATCH_STROBE && !ACTION_SELECT_HI
                 && !ACTION_SELECT_LO && !BYTE_SELECT_ONE)
        begin
            nxt.mode = 1'b1;
        end

        // load strobe actions; bytes persist until reloaded
        if (cur.mode && ld_rise)
        begin
            unique case ({ACTION_SELECT_HI, ACTION_SELECT_LO})
                ACT_ADDR:
                begin
                    if (BYTE_SELECT_ONE)
                    begin
                        nxt.addr_hi = DATA_IN;
                    end
                    else
                    begin
                        nxt.addr_lo = DATA_IN;
                    end
                end
                ACT_DATA:
                begin
                    if (BYTE_SELECT_ONE)
                    begin
                        nxt.data_hi = DATA_IN;
                    end
                    else
                    begin
                        nxt.data_lo = DATA_IN;
                    end
                end
                ACT_CMD:
                begin
                    // commands during busy are dropped to protect the walk
                    if (cur.rdy)
                    begin
                        nxt.cmd = DATA_IN;
                        if (DATA_IN == CMD_NOP)
                        begin
                            nxt.bvalid = '0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end

        // fifo drain into page buffer; a same-cycle set beats the clear
        if (f_out_valid && f_out_ready)
        begin
            bf_we = 1'b1;
            bf_wa = f_out_data[FW-1:16];
            bf_wd = f_out_data[15:0];
            nxt.bvalid[f_out_data[FW-1:16]] = 1'b1;
        end

        if (cur.st != ST_IDLE && cur.cnt != '0)
        begin
            nxt.cnt = cur.cnt - 32'h1;
        end

        unique case (cur.st)
            ST_IDLE:
            begin
                if (cur.mode && wr_fall)
                begin
                    nxt.idx = '0;
                    nxt.cnt = 32'(PROG_CYCLES);
                    if (cur.cmd == CMD_ERASE)
                    begin
                        nxt.st = ST_ERASE_FL;
                        nxt.cnt = 32'(ERASE_CYCLES);
                    end
                    else if (cur.cmd == CMD_WR_FLASH)
                    begin
                        nxt.st = ST_DRAIN;
                    end
                    else if (cur.cmd == CMD_WR_EEPROM && !BYTE_SELECT_ONE)
                    begin
                        nxt.st = ST_DRAIN;
                    end
                    else if (cur.cmd == CMD_WR_FUSE)
                    begin
                        // 0 programs, 1 erases: the byte is stored as given
                        nxt.st = ST_WAIT;
                        unique case ({BYTE_SELECT_TWO, BYTE_SELECT_ONE})
                            FSEL_LOW: nxt.fuse_low = cur.data_lo;
                            FSEL_HIGH: nxt.fuse_high = cur.data_lo;
                            FSEL_EXT: nxt.fuse_ext = cur.data_lo;
                            default: nxt.st = ST_IDLE;
                        endcase
                    end
                end
            end
            ST_DRAIN:
            begin
                // latched words still in flight must land first
                if (!f_out_valid)
                begin
                    nxt.st = (cur.cmd == CMD_WR_EEPROM) ? ST_PROG_EE : ST_PROG_FL;
                end
            end
            ST_ERASE_FL:
            begin
                fl_we = 1'b1;
                fl_wa = cur.idx;
                fl_wd = 16'hffff;
                nxt.idx = cur.idx + 1'b1;
                if (cur.idx == FLASH_ADDR_W'(FLASH_WORDS - 1))
                begin
                    nxt.idx = '0;
                    nxt.lock = LOCK_RST;
                    nxt.st = ee_keep ? ST_WAIT : ST_ERASE_EE;
                end
            end
            ST_ERASE_EE:
            begin
                ee_we = 1'b1;
                ee_wa = cur.idx[EE_ADDR_W-1:0];
                nxt.idx = cur.idx + 1'b1;
                if (cur.idx == FLASH_ADDR_W'(EE_BYTES - 1))
                begin
                    nxt.st = ST_WAIT;
                end
            end
            ST_PROG_FL:
            begin
                // only words latched since the last program are written
                fl_we = cur.bvalid[pidx];
                fl_wa = {faddr[FLASH_ADDR_W-1:PAGE_ADDR_W], pidx};
                fl_wd = page_buf[pidx];
                nxt.idx = cur.idx + 1'b1;
                if (cur.idx == FLASH_ADDR_W'(PAGE_WORDS - 1))
                begin
                    nxt.bvalid = '0;
                    nxt.st = ST_WAIT;
                end
            end
            ST_PROG_EE:
            begin
                ee_we = cur.bvalid[pidx];
                ee_wa = {eaddr[EE_ADDR_W-1:EE_PAGE_ADDR_W],
                         cur.idx[EE_PAGE_ADDR_W-1:0]};
                nxt.idx = cur.idx + 1'b1;
                if (cur.idx == FLASH_ADDR_W'(EE_PAGE - 1))
                begin
                    nxt.bvalid = '0;
                    nxt.st = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (cur.cnt == '0)
                begin
                    nxt.st = ST_IDLE;
                end
            end
        endcase

        // leaving programming mode aborts whatever runs
        if (!cur.mode)
        begin
            nxt.st = ST_IDLE;
        end

        // read path, registered so the bus output comes from a flop
        nxt.dout = 8'hff;
        if (cur.cmd == CMD_RD_FLASH)
        begin
            nxt.dout = BYTE_SELECT_ONE ? flash_mem[faddr][15:8] :
                flash_mem[faddr][7:0];
        end
        else if (cur.cmd == CMD_RD_EEPROM && !BYTE_SELECT_ONE)
        begin
            nxt.dout = ee_mem[eaddr];
        end
        nxt.doe_n = !(cur.mode && !OUTPUT_ENABLE_N);
        nxt.rdy = (nxt.st == ST_IDLE);
        nxt.plr = f_in_ready;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RESET_N)
        begin
            cur <= RST_ST;
        end
        else
        begin
            cur <= nxt;
        end
    end

    // memory arrays; contents survive reset like the real cells
    always_ff @(posedge REF_CLK)
    begin
        if (fl_we)
        begin
            flash_mem[fl_wa] <= fl_wd;
        end
        if (ee_we)
        begin
            ee_mem[ee_wa] <= (cur.st == ST_ERASE_EE) ? 8'hff : page_buf[pidx][7:0];
        end
        if (bf_we)
        begin
            page_buf[bf_wa] <= bf_wd;
        end
    end

    assign DATA_OUT = cur.dout;
    assign DATA_OE_N = cur.doe_n;
    assign PROGRAM_DONE_FLAG = cur.rdy;
    assign PROG_MODE = cur.mode;
    assign PAGE_LATCH_READY = cur.plr;
    assign FUSE_LOW = cur.fuse_low;
    assign FUSE_HIGH = cur.fuse_high;
    assign FUSE_EXT = cur.fuse_ext;
    assign LOCK_BITS = cur.lock;
endmodule : ppp_port

//--- ppp_port_sva.sv
`timescale 1ns/100ps
module ppp_port_sva #(
    parameter int PROG_CYCLES = 20,
    parameter int ERASE_CYCLES = 40
) (
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic PROG_HV,
    input wire logic ACTION_SELECT_HI,
    input wire logic ACTION_SELECT_LO,
    input wire logic BYTE_SELECT_ONE,
    input wire logic PAGE_LATCH_STROBE,
    input wire logic WRITE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic DATA_OE_N,
    input wire logic PROGRAM_DONE_FLAG,
    input wire logic PROG_MODE,
    input wire logic [7:0] FUSE_LOW,
    input wire logic [7:0] FUSE_HIGH,
    input wire logic [7:0] FUSE_EXT,
    input wire logic [7:0] LOCK_BITS
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // array walks outlast the timer, so the ceiling is generous
    localparam int BUSY_MAX = ERASE_CYCLES + 65536;
    int busy_cnt_ff;
    int nxt_busy_cnt;
    logic pins_zero;
    // busy length counter
    assign nxt_busy_cnt = (!RESET_N || PROGRAM_DONE_FLAG) ? 0 : busy_cnt_ff + 1;
    assign pins_zero = !(PAGE_LATCH_STROBE | ACTION_SELECT_HI | ACTION_SELECT_LO
        | BYTE_SELECT_ONE);
    always_ff @(posedge REF_CLK)
    begin
        busy_cnt_ff <= nxt_busy_cnt;
    end
    sequence busy_fall_s;
        PROGRAM_DONE_FLAG ##1 !PROGRAM_DONE_FLAG;
    endsequence
    sequence hv_rise_s;
        !PROG_HV [*2] ##1 PROG_HV;
    endsequence
    oe_release_a: assert property (OUTPUT_ENABLE_N |=> DATA_OE_N)
        else $error("data bus driven without output enable");
    oe_drive_a: assert property (PROG_MODE && PROG_HV && !OUTPUT_ENABLE_N |=> !DATA_OE_N)
        else $error("data bus not driven on output enable");
    idle_release_a: assert property (!PROG_HV [*3] |-> DATA_OE_N && !PROG_MODE)
        else $error("bus or mode active without high voltage");
    entry_taken_a: assert property (hv_rise_s ##0 pins_zero |=> PROG_MODE)
        else $error("entry pattern not taken");
    entry_refused_a: assert property (hv_rise_s ##0 !pins_zero |=> !PROG_MODE)
        else $error("wrong entry pattern accepted");
    busy_cause_a: assert property (busy_fall_s |-> !$past(WRITE_N))
        else $error("busy without write strobe");
    busy_min_a: assert property ($rose(PROGRAM_DONE_FLAG) && PROG_HV
        |-> busy_cnt_ff >= PROG_CYCLES)
        else $error("operation ended too early");
    busy_max_a: assert property (!PROGRAM_DONE_FLAG |-> busy_cnt_ff < BUSY_MAX)
        else $error("busy never ends");
    fuse_hold_a: assert property (!$stable({FUSE_LOW, FUSE_HIGH, FUSE_EXT})
        |-> !PROGRAM_DONE_FLAG || !$past(PROGRAM_DONE_FLAG))
        else $error("fuse changed outside an operation");
    lock_hold_a: assert property ($changed(LOCK_BITS) |-> !$past(PROGRAM_DONE_FLAG))
        else $error("lock byte changed outside an erase");
endmodule : ppp_port_sva

bind ppp_port ppp_port_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_sva (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .PROG_HV(PROG_HV),
    .ACTION_SELECT_HI(ACTION_SELECT_HI), .ACTION_SELECT_LO(ACTION_SELECT_LO),
    .BYTE_SELECT_ONE(BYTE_SELECT_ONE), .PAGE_LATCH_STROBE(PAGE_LATCH_STROBE),
    .WRITE_N(WRITE_N), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .DATA_OE_N(DATA_OE_N),
    .PROGRAM_DONE_FLAG(PROGRAM_DONE_FLAG), .PROG_MODE(PROG_MODE), .FUSE_LOW(FUSE_LOW),
    .FUSE_HIGH(FUSE_HIGH), .FUSE_EXT(FUSE_EXT), .LOCK_BITS(LOCK_BITS)
);

//--- ppp_prog.sv
`timescale 1ns/100ps
module ppp_prog
    import ppp_pkg::*;
(
    input wire logic clk,
    input wire logic dev_oe_n,
    input wire logic [7:0] dev_data,
    output logic hv,
    output logic [1:0] act,
    output logic sel_one,
    output logic sel_two,
    output logic load,
    output logic latch_stb,
    output logic wr_n,
    output logic oe_n,
    output logic [7:0] bus
);
    logic [7:0] drv_val;
    logic drv_en;
    // released bus shows the inverse of the last byte, never a lucky match
    assign bus = !dev_oe_n ? dev_data : (drv_en ? drv_val : ~drv_val);
    initial
    begin
        {hv, act, sel_one, sel_two, load, latch_stb, drv_en} = 8'h00;
        wr_n = 1'b1;
        oe_n = 1'b1;
        drv_val = 8'h00;
    end
    // entry pattern stands before and long after the high voltage
    task automatic enter(input logic [1:0] pat, input int hold);
        @(negedge clk);
        act = pat;
        @(negedge clk);
        hv = 1'b1;
        repeat (hold) @(negedge clk);
        act = 2'h3;
    endtask : enter
    task automatic leave();
        @(negedge clk);
        hv = 1'b0;
        repeat (4) @(negedge clk);
    endtask : leave
    // selects and data held across the whole strobe
    task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] d);
        @(negedge clk);
        act = a;
        sel_one = b;
        drv_val = d;
        drv_en = 1'b1;
        @(negedge clk);
        load = 1'b1;
        repeat (2) @(negedge clk);
        load = 1'b0;
        @(negedge clk);
        drv_en = 1'b0;
        act = 2'h3;
    endtask : ld
    task automatic latch(input logic b);
        @(negedge clk);
        sel_one = b;
        @(negedge clk);
        latch_stb = 1'b1;
        @(negedge clk);
        latch_stb = 1'b0;
    endtask : latch
    // caller waits for ready before further commands, except the second write of the extended fuse step
    task automatic wr(input logic b1, input logic b2);
        @(negedge clk);
        sel_one = b1;
        sel_two = b2;
        @(negedge clk);
        wr_n = 1'b0;
        repeat (3) @(negedge clk);
        wr_n = 1'b1;
        sel_two = 1'b0;
    endtask : wr
    task automatic rd(input logic b, output logic [7:0] v);
        @(negedge clk);
        sel_one = b;
        oe_n = 1'b0;
        repeat (2) @(negedge clk);
        v = bus;
        oe_n = 1'b1;
    endtask : rd
endmodule : ppp_prog

//--- test_ppp_port.sv
`timescale 1ns/100ps
module test_ppp_port
    import ppp_pkg::*;
();
    localparam int ENTRY_WAIT = 75000; // 300 us of 4 ns cycles
    localparam int LIMIT = 100000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hv, sel_one, sel_two, load, latch_stb, wr_n, oe_n, data_oe_n, done, mode, pl_ready;
    logic [1:0] act;
    logic [7:0] bus, data_out, fuse_lo, fuse_hi, fuse_ext, lock, seed, v;
    logic [7:0] fl_lo [4];
    logic [7:0] fl_hi [4];
    logic [7:0] ee [4];
    logic [7:0] fz [3];
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    ppp_port #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .FLASH_ADDR_W(10)) u_dut (
        .REF_CLK(clk), .RESET_N(rst_n), .PROG_HV(hv), .ACTION_SELECT_HI(act[1]),
        .ACTION_SELECT_LO(act[0]), .BYTE_SELECT_ONE(sel_one), .BYTE_SELECT_TWO(sel_two),
        .LOAD_STROBE(load), .PAGE_LATCH_STROBE(latch_stb), .WRITE_N(wr_n),
        .OUTPUT_ENABLE_N(oe_n), .DATA_IN(bus), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n),
        .PROGRAM_DONE_FLAG(done), .PROG_MODE(mode), .PAGE_LATCH_READY(pl_ready),
        .FUSE_LOW(fuse_lo), .FUSE_HIGH(fuse_hi), .FUSE_EXT(fuse_ext), .LOCK_BITS(lock));
    ppp_prog u_prog (.clk(clk), .dev_oe_n(data_oe_n), .dev_data(data_out), .hv(hv), .act(act),
        .sel_one(sel_one), .sel_two(sel_two), .load(load), .latch_stb(latch_stb),
        .wr_n(wr_n), .oe_n(oe_n), .bus(bus));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // busy seen first, then a bounded wait for ready
    task automatic wait_done();
        int n = 0;
        check({7'h00, done}, 8'h00);
        while (done !== 1'b1 && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        check({7'h00, done}, 8'h01);
    endtask : wait_done
    task automatic rd_chk(input logic b, input logic [7:0] exp);
        u_prog.rd(b, v);
        check(v, exp);
        @(negedge clk);
        check({7'h00, data_oe_n}, 8'h01);
    endtask : rd_chk
    // erase; with keep the latch buffer is also overfilled while busy
    task automatic erase(input logic keep);
        u_prog.ld(ACT_CMD, 1'b0, CMD_ERASE);
        u_prog.wr(1'b0, 1'b0);
        for (int i = 0; keep && i < FIFO_DEPTH + 2; i++)
            u_prog.latch(1'b1);
        if (keep)
            check({7'h00, pl_ready}, 8'h00);
        wait_done();
        repeat (80) @(negedge clk);
        check({7'h00, pl_ready}, 8'h01);
        u_prog.ld(ACT_CMD, 1'b0, CMD_NOP);
        check(lock, LOCK_RST);
        check(fuse_hi, fz[1]);
        u_prog.ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
        u_prog.ld(ACT_ADDR, 1'b1, 8'h02);
        u_prog.ld(ACT_ADDR, 1'b0, 8'h7c);
        rd_chk(1'b1, 8'hff);
        u_prog.ld(ACT_CMD, 1'b0, CMD_RD_EEPROM);
        u_prog.ld(ACT_ADDR, 1'b1, 8'h03);
        u_prog.ld(ACT_ADDR, 1'b0, 8'hfd);
        rd_chk(1'b0, keep ? ee[1] : 8'hff);
    endtask : erase
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        seed = 8'h5f;
        fz = '{FUSE_LOW_RST, FUSE_HIGH_RST, FUSE_EXT_RST};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check(fuse_lo, FUSE_LOW_RST);
        check(fuse_ext, FUSE_EXT_RST);
        check({6'h00, done, mode}, 8'h02);
        u_prog.enter(ACT_CMD, 4);
        check({7'h00, mode}, 8'h00);
        u_prog.leave();
        u_prog.enter(ACT_ADDR, ENTRY_WAIT);
        check({7'h00, mode}, 8'h01);
        erase(1'b0);
        // last four words of a page, and the last four bytes of an eeprom page
        for (int m = 0; m < 2; m++)
        begin
            u_prog.ld(ACT_CMD, 1'b0, m ? CMD_WR_EEPROM : CMD_WR_FLASH);
            u_prog.ld(ACT_ADDR, 1'b1, m ? 8'h03 : 8'h02);
            for (int i = 0; i < 4; i++)
            begin
                seed = lfsr(seed);
                fl_lo[i] = m ? fl_lo[i] : seed;
                ee[i] = seed;
                seed = lfsr(seed);
                fl_hi[i] = m ? fl_hi[i] : seed;
                u_prog.ld(ACT_ADDR, 1'b0, (m ? 8'hfc : 8'h7c) + 8'(i));
                u_prog.ld(ACT_DATA, 1'b0, m ? ee[i] : fl_lo[i]);
                u_prog.ld(ACT_DATA, 1'b1, fl_hi[i]);
                u_prog.latch(1'b1);
            end
            u_prog.wr(1'b0, 1'b0);
            wait_done();
            u_prog.ld(ACT_CMD, 1'b0, CMD_NOP);
        end
        // one command and one high byte serve every word
        u_prog.ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
        u_prog.ld(ACT_ADDR, 1'b1, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            u_prog.ld(ACT_ADDR, 1'b0, 8'h7c + 8'(i));
            rd_chk(1'b0, fl_lo[i]);
            rd_chk(1'b1, fl_hi[i]);
        end
        u_prog.ld(ACT_ADDR, 1'b0, 8'h7b);
        rd_chk(1'b0, 8'hff);
        u_prog.ld(ACT_ADDR, 1'b1, 8'h03);
        u_prog.ld(ACT_ADDR, 1'b0, 8'h7c);
        rd_chk(1'b1, 8'hff);
        u_prog.ld(ACT_CMD, 1'b0, CMD_RD_EEPROM);
        for (int i = 0; i < 4; i++)
        begin
            u_prog.ld(ACT_ADDR, 1'b0, 8'hfc + 8'(i));
            rd_chk(1'b0, ee[i]);
        end
        // the eeprom-keep fuse is programmed in the high byte
        u_prog.ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
        for (int f = 0; f < 3; f++)
        begin
            seed = lfsr(seed);
            fz[f] = seed;
            if (f == 1)
                fz[f][EE_KEEP_BIT] = 1'b0;
            u_prog.ld(ACT_DATA, 1'b0, fz[f]);
            u_prog.wr(f == 1, f == 2);
            if (f == 2)
                u_prog.wr(1'b0, 1'b0);
            wait_done();
            check(fuse_lo, fz[0]);
            check(fuse_hi, fz[1]);
            check(fuse_ext, fz[2]);
        end
        erase(1'b1);
        fz[1][EE_KEEP_BIT] = 1'b1;
        u_prog.ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
        u_prog.ld(ACT_DATA, 1'b0, fz[1]);
        u_prog.wr(1'b1, 1'b0);
        wait_done();
        erase(1'b0);
        // words latched during the keep erase were dropped by its nop
        u_prog.ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
        u_prog.wr(1'b0, 1'b0);
        wait_done();
        u_prog.ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
        u_prog.ld(ACT_ADDR, 1'b0, 8'hff);
        rd_chk(1'b0, 8'hff);
        rd_chk(1'b1, 8'hff);
        tally_and_finish();
    end
endmodule : test_ppp_port
